// *** logic/csp_status_word_composer.sv ***
`timescale 1ns/1ps
`include "csp_status_regs.svh"
// Functional notes
// - Bit 15 is 1 while the load sits at the torque upper limit, else 0.
// - Bit 13 sets when position deviation exceeds the following error window.
// - Bit 13 returns to 0 only when the deviation or overload alarm is cleared.
// - Bit 12 is 0 and targets are ignored when not enabled, unexcited, halted, stopped or limited.
// - Otherwise bit 12 is 1 and target commands are acted on.
// - Bit 11 is 1 while any limit sensor, prohibit input, soft or mechanical limit is active.
// - Bit 9 rises once initialisation has completed.
// - Bit 7 follows the warning cause and clears by itself when causes go.
// - Bit 4 is 1 whenever main power is present.
// - Halt at 1 requests an immediate stop; at 0 operation is allowed.
module csp_status_word_composer
	import csp_status_pkg::*;
#(
	parameter int INIT_CYC = `INIT_CYCLES,
	parameter int HIST_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Motion core and I/O
	input wire motion_flags_t motion,
	input wire limit_flags_t limits,
	input wire drive_state_t drive,
	input wire logic target_valid,
	input wire logic [31:0] target_position,
	// Outputs to the motion core
	output logic [15:0] csp_status_word,
	output logic target_load,
	output logic [31:0] target_out,
	output logic immediate_stop,
	output logic irq
);
	localparam int HAW = $clog2(HIST_DEPTH);

	// Status composition state
	logic follow_err_reg, follow_err_next;
	logic [15:0] status_reg, status_next;
	logic target_load_reg, target_load_next;
	logic [31:0] target_reg, target_next;
	logic stop_reg, stop_next;
	init_state_t init_reg, init_next;
	logic [15:0] init_cnt_reg, init_cnt_next;
	logic limit_any, accept;

	// Register file state
	logic [31:0] ctl_reg, ctl_next;
	logic [`IRQ_WIDTH-1:0] ists_reg, ists_next, imask_reg, imask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	logic [`IRQ_WIDTH-1:0] ev;
	logic [15:0] hist_rd;

	function automatic logic reduce_or6(input limit_flags_t l);
		return l.forward_limit_sensor | l.reverse_limit_sensor |
			l.forward_operation_prohibit | l.reverse_operation_prohibit |
			l.software_limit | l.mechanical_limit;
	endfunction

	// Gating terms
	// Halt is control register bit 0, so software alone can close the gate
	always_comb begin
		limit_any = reduce_or6(limits);
		accept = drive.op_enabled && drive.excited && !ctl_reg[`CTL_HALT]
			&& !drive.stop_input && !limit_any;
	end

	// Initialisation countdown
	always_comb begin
		init_next = init_reg;
		init_cnt_next = init_cnt_reg;
		case (init_reg)
			INIT_WAIT: begin
				if (init_cnt_reg >= 16'(INIT_CYC - 1)) begin
					init_next = INIT_DONE;
				end else begin
					init_cnt_next = init_cnt_reg + 16'h0001;
				end
			end
			INIT_DONE: init_next = INIT_DONE;
			default: init_next = INIT_WAIT;
		endcase
	end

	// Status word and target path
	always_comb begin
		follow_err_next = follow_err_reg;
		if (motion.deviation_over_window) begin
			follow_err_next = 1'b1;
		end else if (motion.deviation_alarm_clear || motion.overload_alarm_clear) begin
			follow_err_next = 1'b0;
		end
		status_next = 16'h0000;
		status_next[`BIT_TORQUE_LIMIT] = motion.torque_at_limit;
		status_next[`BIT_FOLLOW_ERR] = follow_err_next;
		status_next[`BIT_TARGET_ACCEPT] = accept;
		status_next[`BIT_INT_LIMIT] = limit_any;
		status_next[`BIT_REMOTE] = (init_reg == INIT_DONE);
		status_next[`BIT_WARNING] = motion.warning_cause;
		status_next[6:0] = drive.state_bits;
		status_next[`BIT_VOLTAGE] = drive.main_power;
		target_load_next = accept && target_valid;
		target_next = (accept && target_valid) ? target_position : target_reg;
		stop_next = ctl_reg[`CTL_HALT];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			follow_err_reg <= 1'b0;
			status_reg <= 16'h0000;
			target_load_reg <= 1'b0;
			target_reg <= 32'h0000_0000;
			stop_reg <= 1'b0;
			init_reg <= INIT_WAIT;
			init_cnt_reg <= 16'h0000;
		end else begin
			follow_err_reg <= follow_err_next;
			status_reg <= status_next;
			target_load_reg <= target_load_next;
			target_reg <= target_next;
			stop_reg <= stop_next;
			init_reg <= init_next;
			init_cnt_reg <= init_cnt_next;
		end
	end

	// Recent status words, readable for diagnosis
	status_history_mem #(.DEPTH(HIST_DEPTH), .AW(HAW)) hist_u (
		.clk(clk),
		.rst(rst),
		.wr_en(status_next != status_reg),
		.wr_data(status_next),
		.rd_addr(HAW'(ctl_reg[8 +: HAW])),
		.rd_data(hist_rd)
	);

	// APB slave, zero wait states; events set sticky bits, read clears
	always_comb begin
		ev = '0;
		ev[`IRQ_FOLLOW] = follow_err_next & ~follow_err_reg;
		ev[`IRQ_LIMIT] = limit_any & ~status_reg[`BIT_INT_LIMIT];
		ev[`IRQ_WARN] = motion.warning_cause & ~status_reg[`BIT_WARNING];
		ev[`IRQ_TORQUE] = motion.torque_at_limit & ~status_reg[`BIT_TORQUE_LIMIT];
		ctl_next = ctl_reg;
		imask_next = imask_reg;
		ists_next = ists_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			pready_next = 1'b1;
			case (paddr)
				`OFS_STATUS_WORD: prdata_next = {16'h0000, status_reg};
				`OFS_CONTROL: prdata_next = ctl_reg;
				`OFS_IRQ_STATUS: prdata_next = {28'h000_0000, ists_reg};
				`OFS_IRQ_MASK: prdata_next = {28'h000_0000, imask_reg};
				`OFS_HISTORY: prdata_next = {16'h0000, hist_rd};
				default: begin
					prdata_next = 32'h0000_0000;
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (psel && penable && pready_reg) begin
			if (pwrite && paddr == `OFS_CONTROL) begin
				ctl_next = pwdata;
			end
			if (pwrite && paddr == `OFS_IRQ_MASK) begin
				imask_next = pwdata[`IRQ_WIDTH-1:0];
			end
			// Clear only what the read returned; a bit set since setup survives
			if (!pwrite && paddr == `OFS_IRQ_STATUS) begin
				ists_next = ists_reg & ~prdata_reg[`IRQ_WIDTH-1:0];
			end
		end
		ists_next = ists_next | ev; // Set wins over read clear
		irq_next = |(ists_next & imask_next);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_reg <= `CTL_RESET;
			imask_reg <= `IRQ_MASK_RESET;
			ists_reg <= '0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			imask_reg <= imask_next;
			ists_reg <= ists_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign csp_status_word = status_reg;
	assign target_load = target_load_reg;
	assign target_out = target_reg;
	assign immediate_stop = stop_reg;
	assign irq = irq_reg;

	// Checks
	torque_bit_a: assert property (@(posedge clk) disable iff (rst)
		motion.torque_at_limit |=> csp_status_word[15]) else $error("torque bit not set");
	follow_set_a: assert property (@(posedge clk) disable iff (rst)
		motion.deviation_over_window |=> csp_status_word[13]) else $error("follow bit not set");
	follow_hold_a: assert property (@(posedge clk) disable iff (rst)
		follow_err_reg && !motion.deviation_alarm_clear && !motion.overload_alarm_clear
		|=> follow_err_reg) else $error("follow bit dropped early");
	target_block_a: assert property (@(posedge clk) disable iff (rst)
		(drive.stop_input || !drive.excited || limit_any) |=> !csp_status_word[12] && !target_load)
		else $error("target taken while blocked");
	target_take_a: assert property (@(posedge clk) disable iff (rst)
		accept && target_valid |=> target_load && target_out == $past(target_position))
		else $error("target not taken");
	limit_bit_a: assert property (@(posedge clk) disable iff (rst)
		limits.mechanical_limit |=> csp_status_word[11]) else $error("limit bit not set");
	remote_seen_a: assert property (@(posedge clk) disable iff (rst)
		csp_status_word[9] |=> csp_status_word[9]) else $error("remote bit fell");
	warn_clear_a: assert property (@(posedge clk) disable iff (rst)
		!motion.warning_cause |=> !csp_status_word[7]) else $error("warning not cleared");
	voltage_bit_a: assert property (@(posedge clk) disable iff (rst)
		drive.main_power |=> csp_status_word[4]) else $error("voltage bit missing");
	halt_stop_a: assert property (@(posedge clk) disable iff (rst)
		ctl_reg[`CTL_HALT] |=> immediate_stop ##0 !csp_status_word[12])
		else $error("halt not honoured");
	zero_bits_a: assert property (@(posedge clk) disable iff (rst)
		csp_status_word[14] == 1'b0 && csp_status_word[10] == 1'b0 && csp_status_word[8] == 1'b0)
		else $error("unused bits set");
	state_copy_a: assert property (@(posedge clk) disable iff (rst)
		##1 $past(rst) || (csp_status_word[6:5] == $past(drive.state_bits[6:5])
		&& csp_status_word[3:0] == $past(drive.state_bits[3:0]))) else $error("state bits wrong");
	// Cleared sides of the level bits, plus the set side of the warning bit
	torque_clear_a: assert property (@(posedge clk) disable iff (rst)
		!motion.torque_at_limit |=> !csp_status_word[15]) else $error("torque bit stuck");
	follow_drop_a: assert property (@(posedge clk) disable iff (rst)
		!motion.deviation_over_window
		&& (motion.deviation_alarm_clear || motion.overload_alarm_clear)
		|=> !csp_status_word[13]) else $error("follow bit not cleared");
	remote_wait_a: assert property (@(posedge clk) disable iff (rst)
		init_reg == INIT_WAIT |=> !csp_status_word[9]) else $error("remote bit early");
	voltage_off_a: assert property (@(posedge clk) disable iff (rst)
		!drive.main_power |=> !csp_status_word[4]) else $error("voltage bit without power");
	halt_release_a: assert property (@(posedge clk) disable iff (rst)
		!ctl_reg[`CTL_HALT] |=> !immediate_stop) else $error("stop without halt");
	limit_clear_a: assert property (@(posedge clk) disable iff (rst)
		!limit_any |=> !csp_status_word[11]) else $error("limit bit stuck");
	warn_set_a: assert property (@(posedge clk) disable iff (rst)
		motion.warning_cause |=> csp_status_word[7]) else $error("warning not set");

	// Target gate and hold, plus bit 11 for any limit source
	target_gate_a: assert property (@(posedge clk) disable iff (rst)
		(!drive.op_enabled || ctl_reg[`CTL_HALT]) |=> !csp_status_word[12] && !target_load)
		else $error("target open while disabled");
	target_open_a: assert property (@(posedge clk) disable iff (rst)
		accept |=> csp_status_word[12]) else $error("target bit not set");
	target_hold_a: assert property (@(posedge clk) disable iff (rst)
		!(accept && target_valid) |=> $stable(target_out)) else $error("ignored target used");
	limit_any_a: assert property (@(posedge clk) disable iff (rst)
		limit_any |=> csp_status_word[11]) else $error("limit source missed");

	// Interrupt bookkeeping
	sticky_hold_a: assert property (@(posedge clk) disable iff (rst)
		ists_reg[`IRQ_WARN] && !(psel && penable && !pwrite && paddr == `OFS_IRQ_STATUS)
		|=> ists_reg[`IRQ_WARN]) else $error("sticky bit lost");
	irq_masked_a: assert property (@(posedge clk) disable iff (rst)
		imask_reg == '0 && !(psel && penable && pwrite && paddr == `OFS_IRQ_MASK)
		|=> !irq) else $error("irq while masked");

	// APB timing; a master that stretches setup is outside this contract
	apb_ready_a: assert property (@(posedge clk) disable iff (rst)
		psel && !penable |=> pready) else $error("no answer to setup");
	apb_pulse_a: assert property (@(posedge clk) disable iff (rst)
		pready |=> !pready) else $error("pready held too long");
	apb_refuse_a: assert property (@(posedge clk) disable iff (rst)
		psel && !penable && paddr > `OFS_HISTORY
		|=> pslverr && prdata == 32'h0000_0000) else $error("unmapped access answered");

	halt_cov: cover property (@(posedge clk) disable iff (rst) immediate_stop && target_valid);
	limit_cov: cover property (@(posedge clk) disable iff (rst) $rose(csp_status_word[11]));
	target_cov: cover property (@(posedge clk) disable iff (rst) target_load);
	follow_cov: cover property (@(posedge clk) disable iff (rst) $fell(follow_err_reg));
	irq_cov: cover property (@(posedge clk) disable iff (rst) irq);
endmodule

// *** logic/csp_status_regs.svh ***
`ifndef CSP_STATUS_REGS_SVH
`define CSP_STATUS_REGS_SVH
// Register byte offsets
`define OFS_STATUS_WORD 12'h000
`define OFS_CONTROL 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_HISTORY 12'h010
// Status word field positions
`define BIT_TORQUE_LIMIT 15
`define BIT_FOLLOW_ERR 13
`define BIT_TARGET_ACCEPT 12
`define BIT_INT_LIMIT 11
`define BIT_REMOTE 9
`define BIT_WARNING 7
`define BIT_VOLTAGE 4
// Control register fields
`define CTL_HALT 0
`define CTL_RESET 32'h0000_0000
// Interrupt status fields
`define IRQ_FOLLOW 0
`define IRQ_LIMIT 1
`define IRQ_WARN 2
`define IRQ_TORQUE 3
`define IRQ_WIDTH 4
`define IRQ_MASK_RESET 4'h0
// Initialisation delay: 1000 ns at 5 ns clock
`define INIT_TIME_NS 1000
`define CLK_PERIOD_NS 5
`define INIT_CYCLES (`INIT_TIME_NS / `CLK_PERIOD_NS)
`endif

// *** logic/csp_status_pkg.sv ***
package csp_status_pkg;
	// Alarm and sensor inputs from the motion core
	typedef struct packed {
		logic torque_at_limit;
		logic deviation_over_window;
		logic deviation_alarm_clear;
		logic overload_alarm_clear;
		logic warning_cause;
	} motion_flags_t;
	// Internal limit sources
	typedef struct packed {
		logic forward_limit_sensor;
		logic reverse_limit_sensor;
		logic forward_operation_prohibit;
		logic reverse_operation_prohibit;
		logic software_limit;
		logic mechanical_limit;
	} limit_flags_t;
	// Drive state machine context
	typedef struct packed {
		logic [6:0] state_bits;
		logic op_enabled;
		logic excited;
		logic main_power;
		logic stop_input;
	} drive_state_t;
	typedef enum logic [1:0] {
		INIT_WAIT = 2'b00,
		INIT_DONE = 2'b01
	} init_state_t;
endpackage

// *** logic/status_history_mem.sv ***
`timescale 1ns/1ps
// Small history of recent status words; read data registered
module status_history_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write side
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem_reg [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] wptr_next;
	logic [15:0] rd_data_reg;

	// Pointer advance
	always_comb begin
		wptr_next = wr_en ? wptr_reg + 1'b1 : wptr_reg;
	end

	// Storage and registered read
	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_reg <= '0;
			rd_data_reg <= 16'h0000;
		end else begin
			wptr_reg <= wptr_next;
			rd_data_reg <= mem_reg[wptr_reg - 1'b1 - rd_addr];
		end
		if (wr_en) begin
			mem_reg[wptr_reg] <= wr_data;
		end
	end

	assign rd_data = rd_data_reg;
endmodule

// *** sim/target_master_model.sv ***
`timescale 1ns/1ps
// Network master stand-in: one cyclic target per bench request
module target_master_model (
	// Clock
	input wire logic clk,
	// Request from the bench
	input wire logic send,
	input wire logic [31:0] pos,
	// Target stream into the block
	output logic target_valid,
	output logic [31:0] target_position
);
	// Bus toggles between targets so stale data never looks like a repeat
	always @(posedge clk) begin
		target_valid <= send;
		target_position <= send ? pos : ~target_position;
	end
	initial begin
		target_valid = 1'b0;
		target_position = 32'h0000_0000;
	end
endmodule

// *** sim/csp_status_word_composer_tb.sv ***
`timescale 1ns/1ps
`include "csp_status_regs.svh"
// APB access plus motion-core stimulus around the status composer
module csp_status_word_composer_tb;
	import csp_status_pkg::*;
	localparam int INIT_N = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, target_out, target_position, rd;
	logic pready, pslverr, target_load, immediate_stop, irq, target_valid, err;
	logic send = 1'b0;
	logic [31:0] pos = 32'h0000_0000;
	logic [15:0] csp_status_word;
	motion_flags_t motion = '0;
	limit_flags_t limits = '0;
	drive_state_t drive = '0;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	csp_status_word_composer #(.INIT_CYC(INIT_N)) dut_u (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .motion(motion), .limits(limits), .drive(drive),
		.target_valid(target_valid), .target_position(target_position),
		.csp_status_word(csp_status_word), .target_load(target_load), .target_out(target_out),
		.immediate_stop(immediate_stop), .irq(irq));
	target_master_model master_u (.clk(clk), .send(send), .pos(pos),
		.target_valid(target_valid), .target_position(target_position));

	always #2.5 clk = ~clk;
	// Hang guard; whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1); // Only the bench timeout ends a wait
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Settle, then compare the whole word so unused bits are covered too
	task automatic sw(input logic [15:0] exp);
		tick(3);
		chk({16'h0000, csp_status_word}, {16'h0000, exp});
	endtask
	task automatic push(input logic [31:0] p, input logic exp);
		int hits;
		hits = 0;
		@(posedge clk);
		send <= 1'b1;
		pos <= p;
		@(posedge clk);
		send <= 1'b0;
		repeat (6) begin
			@(posedge clk);
			if (target_load === 1'b1) hits++;
		end
		chk(hits, exp);
		if (exp) chk(target_out, p);
	endtask

	initial begin
		tick(12);
		chk({16'h0000, csp_status_word}, 32'h0000_0000);
		rst <= 1'b0;
		tick(2);
		chk({31'h0, csp_status_word[9]}, 32'h0000_0000);
		tick(INIT_N + 4);
		chk({31'h0, csp_status_word[9]}, 32'h0000_0001);
		apb(1'b0, `OFS_IRQ_MASK, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		$display("reset and map done");
		// Operation enabled, excited, powered; voltage bit of state left 0
		drive <= '{state_bits: 7'h27, op_enabled: 1'b1, excited: 1'b1, main_power: 1'b1,
			stop_input: 1'b0};
		sw(16'h1237);
		apb(1'b0, `OFS_STATUS_WORD, 32'h0000_0000);
		chk(rd, 32'h0000_1237);
		drive.main_power <= 1'b0;
		sw(16'h1227);
		drive.main_power <= 1'b1;
		motion.torque_at_limit <= 1'b1;
		sw(16'h9237);
		motion.torque_at_limit <= 1'b0;
		sw(16'h1237);
		for (int i = 0; i < 6; i++) begin
			limits <= limit_flags_t'(6'h01 << i);
			sw(16'h0A37);
		end
		push(32'h0000_1111, 1'b0);
		limits <= '0;
		sw(16'h1237);
		for (int i = 0; i < 3; i++) begin
			drive.op_enabled <= (i != 0);
			drive.excited <= (i != 1);
			drive.stop_input <= (i == 2);
			sw(16'h0237);
		end
		drive.stop_input <= 1'b0;
		sw(16'h1237);
		push(32'h1234_5678, 1'b1);
		$display("status bits done");
		apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
		sw(16'h0237);
		chk({31'h0, immediate_stop}, 32'h0000_0001);
		push(32'h0000_2222, 1'b0);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0000);
		sw(16'h1237);
		chk({31'h0, immediate_stop}, 32'h0000_0000);
		$display("halt done");
		// Error holds after the deviation goes; only an alarm clear drops it
		for (int j = 0; j < 2; j++) begin
			motion.deviation_over_window <= 1'b1;
			tick(1);
			motion.deviation_over_window <= 1'b0;
			sw(16'h3237);
			tick(6);
			sw(16'h3237);
			if (j == 0) motion.deviation_alarm_clear <= 1'b1;
			else motion.overload_alarm_clear <= 1'b1;
			tick(1);
			motion.deviation_alarm_clear <= 1'b0;
			motion.overload_alarm_clear <= 1'b0;
			sw(16'h1237);
		end
		$display("following error done");
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_000B);
		motion.warning_cause <= 1'b1;
		sw(16'h12B7);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0004);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0004);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0000);
		motion.warning_cause <= 1'b0;
		sw(16'h1237);
		$display("warning and interrupt done");
		// Newest change first: warning cleared, then warning raised
		apb(1'b0, `OFS_HISTORY, 32'h0000_0000);
		chk(rd, 32'h0000_1237);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0100);
		apb(1'b0, `OFS_HISTORY, 32'h0000_0000);
		chk(rd, 32'h0000_12B7);
		$display("history done");
		print_verdict();
	end
endmodule
